// [logic/fwac_pkg.sv]
// Purpose: Constants for the FIFO write path and auxiliary poll configuration block.
// Assumes: 50 MHz clock, AHB-Lite register access with one aligned word per register.
// Notes: Printed offsets are register indices; byte address is four times the index.
`default_nettype none
package fwac_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   // Register indices; byte address is four times the index.
   localparam logic [7:0] IDX_AUX_POLL = 8'h44;
   localparam logic [7:0] IDX_DECIM = 8'h45;
   localparam logic [7:0] IDX_WTM_LO = 8'h46;
   localparam logic [7:0] IDX_WTM_HI = 8'h47;
   localparam logic [7:0] IDX_POLICY = 8'h48;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h50;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h51;
   localparam logic [7:0] IDX_STATUS = 8'h52;
   // Reset values.
   localparam logic [7:0] RST_AUX_POLL = 8'h46;
   localparam logic [7:0] RST_DECIM = 8'h88;
   localparam logic [7:0] RST_WTM_LO = 8'h00;
   localparam logic [7:0] RST_WTM_HI = 8'h02;
   localparam logic [7:0] RST_POLICY = 8'h02;
   localparam logic [7:0] RST_IRQ_MASK = 8'h00;
   // Field positions.
   localparam int unsigned F_RATE_LSB = 0;
   localparam int unsigned F_OFFS_LSB = 4;
   localparam int unsigned F_GDOWN_LSB = 0;
   localparam int unsigned F_GFILT = 3;
   localparam int unsigned F_ADOWN_LSB = 4;
   localparam int unsigned F_AFILT = 7;
   localparam int unsigned F_STOP_FULL = 0;
   localparam int unsigned F_TIME_EN = 1;
   localparam int unsigned IRQ_WTM = 0;
   localparam int unsigned IRQ_FULL = 1;
   localparam int unsigned IRQ_DROP = 2;
   // Poll rate codes.
   localparam logic [3:0] RATE_MIN = 4'h1;
   localparam logic [3:0] RATE_MAX = 4'hb;
   // Timing: 25/32 Hz base period is 1.28 s; 800 Hz is 1.25 ms.
   localparam int unsigned BASE_PERIOD_US = 1_280_000;
   localparam int unsigned OFFS_STEP_US = 2500;
   localparam int unsigned OFFS_STEP_CYC = OFFS_STEP_US * (CLK_HZ / 1_000_000);
   localparam int unsigned FAST_PERIOD_US = 1250;
   localparam int unsigned FAST_PERIOD_CYC = FAST_PERIOD_US * (CLK_HZ / 1_000_000);
   localparam logic [3:0] OFFS_MAX_STEPS = 4'hf;
   localparam int unsigned FIFO_BYTES = 2048;
   localparam logic [7:0] AHB_TRANS_NONSEQ = 8'h02;
   typedef enum logic [1:0] {AUX_IDLE, AUX_WAIT_TRIG, AUX_WAIT_READ} fwac_aux_state_type;
endpackage
`default_nettype wire

// [logic/fwac_top.sv]
// Purpose: Register file and control for the sensor FIFO write path and auxiliary poll timing.
// Assumes: Synchronous active-high reset, clock enable freezes all state, AHB-Lite slave.
// Notes: The FIFO store itself sits outside; this block issues write strobes and checks the fill level against the watermark.
// How it works
// R01 - Poll rate code 1 gives 25/32 Hz and doubles per step to 800 Hz at code 0xb, others are reserved.
// R02 - The poll schedule depends on the rate code, the offset field and readout completion, never on the aux power mode.
// R03 - Software must also set up the aux link setup register before polling works.
// R04 - Each aux trigger is followed by its readout after the offset field times 2.5 ms, reset 0x4.
// R05 - An offset of zero means the maximum offset, so a trigger follows each readout at once.
// R06 - Gyro samples are kept one in two to the power of the gyro exponent, zero keeps all.
// R07 - Accel samples are kept one in two to the power of the accel exponent, zero keeps all.
// R08 - Gyro source bit zero picks unfiltered and one picks filtered data, reset filtered.
// R09 - Accel source bit zero picks unfiltered and one picks filtered data, reset filtered.
// R10 - The watermark is the low eight bits plus the high five bits times 256 bytes.
// R11 - With halt-when-full set, no new samples are written once the FIFO is full.
// R12 - With halt-when-full clear, its reset value, samples keep being written when full.
// R13 - With the time frame enable set, its reset value, a sensortime frame follows the last data.
// R14 - The watermark holds whenever the fill level is at least the programmed threshold.
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module fwac_top
   import fwac_pkg::*;
#(
   parameter int unsigned BASE_PERIOD_CYC = BASE_PERIOD_US * (CLK_HZ / 1_000_000) / 1024,
   parameter int unsigned OFFS_CYC = OFFS_STEP_CYC
)
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic IRQ,
   input wire logic GYR_SAMPLE_VALID,
   input wire logic [15:0] GYR_FILT_DATA,
   input wire logic [15:0] GYR_RAW_DATA,
   input wire logic ACC_SAMPLE_VALID,
   input wire logic [15:0] ACC_FILT_DATA,
   input wire logic [15:0] ACC_RAW_DATA,
   output logic GYR_FIFO_WR,
   output logic [15:0] GYR_FIFO_DATA,
   output logic ACC_FIFO_WR,
   output logic [15:0] ACC_FIFO_DATA,
   input wire logic [11:0] FIFO_FILL_BYTES,
   input wire logic FIFO_FULL,
   output logic FIFO_TIME_FRAME_EN,
   output logic AUX_TRIGGER,
   output logic AUX_READOUT,
   input wire logic AUX_READOUT_DONE
);
   // ------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------
   logic [7:0] aux_poll_config_q;
   logic [7:0] fifo_decimation_config_q;
   logic [7:0] watermark_low_byte_q;
   logic [7:0] watermark_high_bits_q;
   logic [7:0] buffer_write_policy_q;
   logic [2:0] irq_stat_q;
   logic [2:0] irq_mask_q;
   // Status flags are read by the register decode before their logic below.
   logic wm_hit;
   logic aux_busy;
   // ------------------------------------------------------------
   // AHB-Lite slave
   // ------------------------------------------------------------
   logic wr_pend_q;
   logic [7:0] wr_idx_q;
   wire addr_phase = HSEL && HREADY && HTRANS[1];
   wire [7:0] a_idx = HADDR[9:2];
   wire word_ok = (HSIZE == 3'b010) && (HADDR[1:0] == 2'b00) && (HADDR[31:10] == 22'h0);
   wire wr_take = addr_phase && HWRITE && word_ok;
   wire rd_take = addr_phase && !HWRITE && word_ok;
   wire wr_aux = wr_pend_q && (wr_idx_q == IDX_AUX_POLL);
   wire wr_dec = wr_pend_q && (wr_idx_q == IDX_DECIM);
   wire wr_wlo = wr_pend_q && (wr_idx_q == IDX_WTM_LO);
   wire wr_whi = wr_pend_q && (wr_idx_q == IDX_WTM_HI);
   wire wr_pol = wr_pend_q && (wr_idx_q == IDX_POLICY);
   wire wr_ist = wr_pend_q && (wr_idx_q == IDX_IRQ_STAT);
   wire wr_msk = wr_pend_q && (wr_idx_q == IDX_IRQ_MASK);
   logic [7:0] rd_val;
   always_comb
   begin
      case (a_idx)
         IDX_AUX_POLL: rd_val = aux_poll_config_q;
         IDX_DECIM: rd_val = fifo_decimation_config_q;
         IDX_WTM_LO: rd_val = watermark_low_byte_q;
         IDX_WTM_HI: rd_val = watermark_high_bits_q;
         IDX_POLICY: rd_val = buffer_write_policy_q;
         IDX_IRQ_STAT: rd_val = {5'h0, irq_stat_q};
         IDX_IRQ_MASK: rd_val = {5'h0, irq_mask_q};
         IDX_STATUS: rd_val = {5'h0, FIFO_FULL, wm_hit, aux_busy};
         default: rd_val = 8'h00;
      endcase
   end
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 8'h00;
         HRDATA <= 32'h0000_0000;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
      else if (CLK_EN)
      begin
         wr_pend_q <= wr_take;
         wr_idx_q <= a_idx;
         if (rd_take)
            HRDATA <= {24'h00_0000, rd_val};
      end
   end
   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         aux_poll_config_q <= RST_AUX_POLL;
         fifo_decimation_config_q <= RST_DECIM;
         watermark_low_byte_q <= RST_WTM_LO;
         watermark_high_bits_q <= RST_WTM_HI;
         buffer_write_policy_q <= RST_POLICY;
         irq_mask_q <= 3'b000;
      end
      else if (CLK_EN)
      begin
         if (wr_aux)
            aux_poll_config_q <= HWDATA[7:0];
         if (wr_dec)
            fifo_decimation_config_q <= HWDATA[7:0]; // [R08] [R09]
         if (wr_wlo)
            watermark_low_byte_q <= HWDATA[7:0];
         if (wr_whi)
            watermark_high_bits_q <= {3'b000, HWDATA[4:0]};
         if (wr_pol)
            buffer_write_policy_q <= {6'h00, HWDATA[1:0]};
         if (wr_msk)
            irq_mask_q <= HWDATA[2:0];
      end
   end
   // ------------------------------------------------------------
   // FIFO write path
   // ------------------------------------------------------------
   wire [2:0] gyr_exp = fifo_decimation_config_q[F_GDOWN_LSB +: 3];
   wire [2:0] acc_exp = fifo_decimation_config_q[F_ADOWN_LSB +: 3];
   wire gyr_filt = fifo_decimation_config_q[F_GFILT];
   wire acc_filt = fifo_decimation_config_q[F_AFILT];
   wire stop_full = buffer_write_policy_q[F_STOP_FULL];
   logic [6:0] gyr_cnt_q;
   logic [6:0] acc_cnt_q;
   wire [6:0] gyr_mask = 7'((8'd1 << gyr_exp) - 8'd1);
   wire [6:0] acc_mask = 7'((8'd1 << acc_exp) - 8'd1);
   wire gyr_keep = (gyr_cnt_q & gyr_mask) == 7'h00; // [R06]
   wire acc_keep = (acc_cnt_q & acc_mask) == 7'h00; // [R07]
   wire wr_block = stop_full && FIFO_FULL; // [R11] [R12]
   wire gyr_wr = GYR_SAMPLE_VALID && gyr_keep && !wr_block;
   wire acc_wr = ACC_SAMPLE_VALID && acc_keep && !wr_block;
   wire drop_ev = (GYR_SAMPLE_VALID && gyr_keep || ACC_SAMPLE_VALID && acc_keep) && wr_block;
   wire [12:0] wm_level = {watermark_high_bits_q[4:0], watermark_low_byte_q}; // [R10]
   assign wm_hit = {1'b0, FIFO_FILL_BYTES} >= wm_level; // [R14]
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         gyr_cnt_q <= 7'h00;
         acc_cnt_q <= 7'h00;
         GYR_FIFO_WR <= 1'b0;
         ACC_FIFO_WR <= 1'b0;
         GYR_FIFO_DATA <= 16'h0000;
         ACC_FIFO_DATA <= 16'h0000;
         FIFO_TIME_FRAME_EN <= 1'b1;
      end
      else if (CLK_EN)
      begin
         if (GYR_SAMPLE_VALID)
            gyr_cnt_q <= (gyr_cnt_q + 7'h01) & gyr_mask;
         if (ACC_SAMPLE_VALID)
            acc_cnt_q <= (acc_cnt_q + 7'h01) & acc_mask;
         GYR_FIFO_WR <= gyr_wr;
         ACC_FIFO_WR <= acc_wr;
         if (gyr_wr)
            GYR_FIFO_DATA <= gyr_filt ? GYR_FILT_DATA : GYR_RAW_DATA; // [R08]
         if (acc_wr)
            ACC_FIFO_DATA <= acc_filt ? ACC_FILT_DATA : ACC_RAW_DATA; // [R09]
         FIFO_TIME_FRAME_EN <= buffer_write_policy_q[F_TIME_EN]; // [R13]
      end
   end
   // ------------------------------------------------------------
   // Interrupt status
   // ------------------------------------------------------------
   wire [2:0] irq_ev = {drop_ev, FIFO_FULL, wm_hit};
   wire [2:0] irq_clr = wr_ist ? HWDATA[2:0] : 3'b000;
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         irq_stat_q <= 3'b000;
         IRQ <= 1'b0;
      end
      else if (CLK_EN)
      begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
         IRQ <= |(((irq_stat_q & ~irq_clr) | irq_ev) & irq_mask_q);
      end
   end
   // ------------------------------------------------------------
   // Auxiliary poll scheduling
   // ------------------------------------------------------------
   wire [3:0] rate = aux_poll_config_q[F_RATE_LSB +: 4];
   wire [3:0] offs = aux_poll_config_q[F_OFFS_LSB +: 4];
   wire rate_ok = (rate >= RATE_MIN) && (rate <= RATE_MAX); // [R01]
   // The base period belongs to the fastest code, so each lower code doubles it.
   wire [31:0] period_cyc = 32'(BASE_PERIOD_CYC) << (RATE_MAX - rate); // [R01] [R02]
   wire [3:0] offs_steps = (offs == 4'h0) ? OFFS_MAX_STEPS : offs; // [R05]
   wire [31:0] offs_cyc = 32'(OFFS_CYC) * {28'h0, offs_steps}; // [R04]
   fwac_aux_state_type aux_q;
   logic [31:0] per_cnt_q;
   logic [31:0] off_cnt_q;
   assign aux_busy = aux_q != AUX_IDLE;
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         aux_q <= AUX_IDLE;
         per_cnt_q <= 32'h0000_0000;
         off_cnt_q <= 32'h0000_0000;
         AUX_TRIGGER <= 1'b0;
         AUX_READOUT <= 1'b0;
      end
      else if (CLK_EN)
      begin
         AUX_TRIGGER <= 1'b0;
         AUX_READOUT <= 1'b0;
         per_cnt_q <= (per_cnt_q + 32'd1 >= period_cyc) ? 32'h0000_0000 : per_cnt_q + 32'd1;
         case (aux_q)
            AUX_IDLE:
            begin
               if (rate_ok && (per_cnt_q + 32'd1 >= period_cyc))
               begin
                  AUX_TRIGGER <= 1'b1;
                  off_cnt_q <= 32'h0000_0000;
                  aux_q <= AUX_WAIT_TRIG;
               end
            end
            AUX_WAIT_TRIG:
            begin
               off_cnt_q <= off_cnt_q + 32'd1;
               if (off_cnt_q + 32'd1 >= offs_cyc) // [R04]
               begin
                  AUX_READOUT <= 1'b1;
                  aux_q <= AUX_WAIT_READ;
               end
            end
            AUX_WAIT_READ:
            begin
               if (AUX_READOUT_DONE)
               begin
                  if (offs == 4'h0 && rate_ok) // [R05]
                  begin
                     AUX_TRIGGER <= 1'b1;
                     off_cnt_q <= 32'h0000_0000;
                     aux_q <= AUX_WAIT_TRIG;
                  end
                  else
                     aux_q <= AUX_IDLE;
               end
            end
            default: aux_q <= AUX_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// [bench/fwac_fifo_model.sv]
// Purpose: Far side model holding the FIFO fill level and answering aux readouts.
// Assumes: Every kept sample adds two bytes; a flush empties the store.
// Notes: When full the oldest data is overwritten, so the level stays put.
`timescale 1ns/100ps
`default_nettype none
module fwac_fifo_model
#(
   parameter int unsigned CAP = 64
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic gyr_wr,
   input wire logic acc_wr,
   input wire logic aux_rd,
   output logic [11:0] fill_bytes,
   output logic full,
   output logic aux_done
);
   logic [3:0] dly_q;
   assign full = fill_bytes >= 12'(CAP);
   assign aux_done = dly_q == 4'h1;
   always_ff @(posedge clk)
   begin
      if (rst || flush)
         fill_bytes <= 12'h000;
      else if (!full)
         fill_bytes <= fill_bytes + {10'h000, gyr_wr, 1'b0} + {10'h000, acc_wr, 1'b0};
      if (rst)
         dly_q <= 4'h0;
      else if (aux_rd)
         dly_q <= 4'h5;
      else if (dly_q != 4'h0)
         dly_q <= dly_q - 4'h1;
   end
endmodule
`default_nettype wire

// [bench/fwac_properties.sv]
// Purpose: Concurrent checks on the FIFO write and aux poll ports.
// Assumes: Registers are written by single word transfers.
// Notes: Shadow copies of three registers follow bus writes.
`timescale 1ns/100ps
`default_nettype none
module fwac_properties
   import fwac_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic GYR_SAMPLE_VALID,
   input wire logic [15:0] GYR_FILT_DATA,
   input wire logic [15:0] GYR_RAW_DATA,
   input wire logic GYR_FIFO_WR,
   input wire logic [15:0] GYR_FIFO_DATA,
   input wire logic ACC_SAMPLE_VALID,
   input wire logic [15:0] ACC_FILT_DATA,
   input wire logic [15:0] ACC_RAW_DATA,
   input wire logic ACC_FIFO_WR,
   input wire logic [15:0] ACC_FIFO_DATA,
   input wire logic FIFO_FULL,
   input wire logic FIFO_TIME_FRAME_EN,
   input wire logic AUX_TRIGGER,
   input wire logic AUX_READOUT,
   input wire logic AUX_READOUT_DONE
);
   logic wr_q;
   logic [7:0] idx_q, aux_q, dec_q, pol_q;
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         wr_q <= 1'b0;
         idx_q <= 8'h00;
         aux_q <= RST_AUX_POLL;
         dec_q <= RST_DECIM;
         pol_q <= RST_POLICY;
      end
      else
      begin
         wr_q <= HSEL && HREADY && HTRANS[1] && HWRITE;
         idx_q <= HADDR[9:2];
         if (wr_q && idx_q == IDX_AUX_POLL)
            aux_q <= HWDATA[7:0];
         if (wr_q && idx_q == IDX_DECIM)
            dec_q <= HWDATA[7:0];
         if (wr_q && idx_q == IDX_POLICY)
            pol_q <= HWDATA[7:0];
      end
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);
   AST_GYR_CAUSE: assert property (GYR_FIFO_WR |-> $past(GYR_SAMPLE_VALID))
      else $error("gyro write without a sample");
   AST_ACC_CAUSE: assert property (ACC_FIFO_WR |-> $past(ACC_SAMPLE_VALID))
      else $error("accel write without a sample");
   AST_GYR_SEL: assert property (GYR_FIFO_WR |-> GYR_FIFO_DATA ==
      ($past(dec_q[3]) ? $past(GYR_FILT_DATA) : $past(GYR_RAW_DATA)))
      else $error("gyro source select wrong");
   AST_ACC_SEL: assert property (ACC_FIFO_WR |-> ACC_FIFO_DATA ==
      ($past(dec_q[7]) ? $past(ACC_FILT_DATA) : $past(ACC_RAW_DATA)))
      else $error("accel source select wrong");
   AST_HALT_FULL: assert property ($past(FIFO_FULL && pol_q[0]) |-> !GYR_FIFO_WR && !ACC_FIFO_WR)
      else $error("write while full and halted");
   AST_TRIG_READ: assert property (AUX_TRIGGER |-> ##[1:70] AUX_READOUT)
      else $error("readout missing after trigger");
   AST_ZERO_OFFS: assert property (AUX_READOUT_DONE && aux_q[7:4] == 4'h0 |-> ##[0:3] AUX_TRIGGER)
      else $error("no trigger after readout");
   AST_TIME_EN: assert property (FIFO_TIME_FRAME_EN != pol_q[1] |=> FIFO_TIME_FRAME_EN == pol_q[1])
      else $error("time frame enable wrong");
   cover property (GYR_FIFO_WR && !dec_q[3]);
   cover property (AUX_READOUT_DONE && aux_q[7:4] == 4'h0);
   cover property (FIFO_FULL && pol_q[0] && GYR_SAMPLE_VALID);
endmodule
bind fwac_top fwac_properties i_fwac_properties (.*);
`default_nettype wire

// [bench/fwac_top_bench.sv]
// Purpose: Register and sample path tests for the FIFO write configuration block.
// Assumes: Short poll and offset parameters keep the run brief.
// Notes: Write counts are compared as differences of free running counters.
`timescale 1ns/100ps
`default_nettype none
module fwac_top_bench
   import fwac_pkg::*;
;
   logic clk = 0, rst = 1, sel = 0, hw = 0, gv = 0, av = 0, flush = 0, hro, hrs, irq;
   logic gwr, awr, full, ten, trg, rdo, dn;
   logic [1:0] ht = 0;
   logic [31:0] ha = 0, hwd = 0, hrd, rd;
   logic [15:0] gf = 0, av_d = 0, gd, ad;
   logic [11:0] fill;
   int check_count = 0, fail_count = 0, gcnt = 0, acnt = 0, tcnt = 0, g0, a0, t0;
   logic [7:0] ri [5] = '{IDX_AUX_POLL, IDX_DECIM, IDX_WTM_LO, IDX_WTM_HI, IDX_POLICY};
   logic [7:0] rv [5] = '{8'h46, 8'h88, 8'h00, 8'h02, 8'h02};
   always #10 clk = ~clk;
   always @(posedge clk) gcnt <= gcnt + 32'(gwr);
   always @(posedge clk) acnt <= acnt + 32'(awr);
   always @(posedge clk) tcnt <= tcnt + 32'(trg);
   fwac_top #(.BASE_PERIOD_CYC(8), .OFFS_CYC(4)) i_fwac_top (.CLK(clk), .SYS_RST(rst),
      .CLK_EN(1'b1), .HSEL(sel), .HADDR(ha), .HTRANS(ht), .HWRITE(hw), .HSIZE(3'h2),
      .HWDATA(hwd), .HREADY(hro), .HRDATA(hrd), .HREADYOUT(hro), .HRESP(hrs), .IRQ(irq),
      .GYR_SAMPLE_VALID(gv), .GYR_FILT_DATA(gf), .GYR_RAW_DATA(~gf), .ACC_SAMPLE_VALID(av),
      .ACC_FILT_DATA(av_d), .ACC_RAW_DATA(~av_d), .GYR_FIFO_WR(gwr), .GYR_FIFO_DATA(gd),
      .ACC_FIFO_WR(awr), .ACC_FIFO_DATA(ad), .FIFO_FILL_BYTES(fill), .FIFO_FULL(full),
      .FIFO_TIME_FRAME_EN(ten), .AUX_TRIGGER(trg), .AUX_READOUT(rdo), .AUX_READOUT_DONE(dn));
   fwac_fifo_model i_fwac_fifo_model (.clk(clk), .rst(rst), .flush(flush), .gyr_wr(gwr),
      .acc_wr(awr), .aux_rd(rdo), .fill_bytes(fill), .full(full), .aux_done(dn));
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wt;
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (hro !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         fail_count++;
         report_and_stop();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
      sel <= 1;
      ht <= 2'b10;
      hw <= w;
      ha <= {22'h0, idx, 2'b00};
      wt();
      sel <= 0;
      ht <= 2'b00;
      hwd <= d;
      wt();
      rd = hrd;
   endtask
   task automatic samp(input int n);
      repeat (n)
      begin
         gv <= 1;
         av <= 1;
         gf <= gf + 16'h0101;
         av_d <= av_d + 16'h0203;
         @(posedge clk);
         gv <= 0;
         av <= 0;
         @(posedge clk);
      end
      repeat (3) @(posedge clk);
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 0;
      for (int i = 0; i < 5; i++)
      begin
         bus(0, ri[i], 0);
         chk("reset value", rd, {24'h0, rv[i]});
      end
      chk("okay response", hrs, 0);
      bus(1, 8'h7c, 32'h0000_00ff);
      bus(0, 8'h7c, 0);
      chk("unmapped", rd, 32'h0000_0000);
      $display("test registers done");
      for (int e = 0; e < 4; e++)
      begin
         bus(1, IDX_DECIM, {24'h0, e[0], 3'(e), ~e[0], 3'(e)});
         g0 = gcnt;
         a0 = acnt;
         samp(16);
         chk("gyro kept", gcnt - g0, 16 >> e);
         chk("accel kept", acnt - a0, 16 >> e);
      end
      $display("test decimation done");
      bus(1, IDX_DECIM, 32'h0000_0088);
      flush <= 1;
      @(posedge clk);
      flush <= 0;
      bus(1, IDX_POLICY, 32'h0000_0003);
      g0 = gcnt;
      samp(24);
      chk("halted writes", gcnt - g0, 16);
      bus(1, IDX_POLICY, 32'h0000_0000);
      g0 = gcnt;
      samp(4);
      chk("writes when full", gcnt - g0, 4);
      chk("time frame off", ten, 0);
      $display("test full policy done");
      flush <= 1;
      bus(1, IDX_WTM_HI, 32'h0000_0001);
      flush <= 0;
      bus(1, IDX_IRQ_STAT, 32'h0000_0007);
      bus(1, IDX_IRQ_MASK, 32'h0000_0001);
      samp(4);
      chk("irq above 256", irq, 0);
      flush <= 1;
      bus(1, IDX_WTM_HI, 32'h0000_0000);
      flush <= 0;
      bus(1, IDX_WTM_LO, 32'h0000_0010);
      bus(1, IDX_IRQ_STAT, 32'h0000_0007);
      samp(3);
      chk("irq below", irq, 0);
      samp(1);
      chk("irq at level", irq, 1);
      bus(0, IDX_IRQ_STAT, 0);
      chk("status", rd & 1, 1);
      bus(1, IDX_IRQ_MASK, 32'h0000_0000);
      repeat (2) @(posedge clk);
      chk("irq masked", irq, 0);
      $display("test watermark done");
      // Aux link setup lives outside this block; the model answers readouts alone.
      bus(1, IDX_AUX_POLL, 32'h0000_001b);
      t0 = tcnt;
      repeat (300) @(posedge clk);
      chk("fast triggers", tcnt > t0 + 5, 1);
      bus(1, IDX_AUX_POLL, 32'h0000_0011);
      repeat (100) @(posedge clk);
      t0 = tcnt;
      repeat (300) @(posedge clk);
      chk("slow triggers", tcnt - t0 <= 1, 1);
      bus(1, IDX_AUX_POLL, 32'h0000_000b);
      repeat (100) @(posedge clk);
      t0 = tcnt;
      repeat (300) @(posedge clk);
      chk("zero offset triggers", tcnt - t0 >= 3, 1);
      bus(1, IDX_AUX_POLL, 32'h0000_001c);
      repeat (100) @(posedge clk);
      t0 = tcnt;
      repeat (300) @(posedge clk);
      chk("reserved code triggers", tcnt - t0, 0);
      $display("test aux poll done");
      report_and_stop();
   end
endmodule
`default_nettype wire
